// ### verilog/cau_alu_core.sv
// Execution datapath for increment, compare, multiply, divide and logic.
// Assumes the decoder supplies the fetched operand with each command and
// performs the write-back that the completion outputs ask for.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Increment or decrement by one; N, Z, V updated, carry kept.
// - Long increment or decrement: 7 cycles on register, 9 on memory.
// - Memory operands of increment, decrement and logic are read, modified and written back; compare only reads.
// - Compare subtracts, keeps difference away, sets NZVC; implicit takes 1.
// - Immediate compares of 8, 16 or 32 bits; 32-bit one takes 3.
// - Implicit unsigned byte divide: quotient to low half, remainder high.
// - Unsigned byte divide: 3 zero, 7 overflow, 15 otherwise.
// - Unsigned word divide: quotient to accumulator, remainder to divisor.
// - Divides change only overflow and carry flags.
// - Signed byte divide: 3 by zero, 18 normal, 8 or 18 overflow.
// - Signed word divide: 4 by zero, 10/29 overflow, 30; negative +1.
// - Signed overflow is found before or after the divide loop.
// - After signed divide overflow found after the loop the low half holds garbage.
// - Signed byte multiply: 3 for zero multiplier, 12 positive, 13 negative.
// - Signed word multiply: 3 for zero operand, 16 positive, 19 negative.
// - Byte logic: N, Z updated, V cleared, C kept; immediate 2, register 3.
// - Implicit word logic combines the halves into the low half, 2 cycles.
module cau_alu_core (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Command from the decoder
  input wire logic cmd_valid_i,
  input wire logic [4:0] cmd_op_i,
  input wire logic [1:0] cmd_size_i,
  input wire logic [1:0] cmd_form_i,
  input wire logic [31:0] cmd_opnd_i,
  output logic cmd_ready_o,
  // Completion and write-back
  output logic done_o,
  output logic wb_reg_o,
  output logic wb_mem_o,
  output logic [31:0] wb_data_o,
  output logic [31:0] acc_o,
  output logic [3:0] flags_o,
  // Register port
  input wire logic [1:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'h1,
    ST_EXEC = 2'h2
  } cau_state_t;

  typedef struct packed {
    cau_state_t state;
    logic [31:0] acc;
    logic [3:0] flg;
    logic ready;
    logic done;
    logic wb_reg;
    logic wb_mem;
    logic [31:0] wb_data;
    logic [31:0] rdata;
    logic [31:0] p_acc;
    logic [3:0] p_flg;
    logic p_wreg;
    logic p_wmem;
    logic [31:0] p_wb;
    logic [cau_pkg::CNT_W-1:0] p_cyc;
    cau_pkg::cau_op_t p_op;
    logic [cau_pkg::CNT_W-1:0] run;
  } cau_st_t;

  cau_st_t st;
  cau_st_t next_st;
  cau_pkg::cau_op_t op;
  cau_pkg::cau_size_t sz;
  cau_pkg::cau_form_t fm;
  logic accept;
  logic mem;
  logic neg;
  logic last;
  logic [15:0] ah;
  logic [15:0] al;
  logic [31:0] e_acc;
  logic [3:0] e_flg;
  logic [31:0] e_wb;
  logic e_wreg;
  logic e_wmem;
  logic [cau_pkg::CNT_W-1:0] e_cyc;
  logic [31:0] x;
  logic [31:0] y;
  logic [31:0] r;
  logic [31:0] q;
  logic [31:0] rm;
  logic [31:0] p;
  logic [32:0] sx;
  logic [32:0] sy;
  logic [32:0] sq;
  logic [32:0] srm;
  logic [32:0] mg;
  logic [32:0] ms;

  function automatic logic msb(input logic [31:0] v, input logic [1:0] s);
    msb = (s == cau_pkg::SZ_BYTE) ? v[7] :
          (s == cau_pkg::SZ_WORD) ? v[15] : v[31];
  endfunction : msb

  function automatic logic [31:0] msk(input logic [31:0] v,
                                      input logic [1:0] s);
    msk = (s == cau_pkg::SZ_BYTE) ? {24'h0, v[7:0]} :
          (s == cau_pkg::SZ_WORD) ? {16'h0, v[15:0]} : v;
  endfunction : msk

  // ------------------------------------------------------------------
  // Cycle timer
  // ------------------------------------------------------------------
  cau_tmr_if tif ();

  assign tif.load = accept;
  assign tif.count = e_cyc;
  assign last = tif.last;

  cau_cycle_timer u_timer (
    .core_clk_i (core_clk_i),
    .rst_b_i (rst_b_i),
    .tmr (tif)
  );

  // ------------------------------------------------------------------
  // Datapath and sequencing
  // ------------------------------------------------------------------
  // Results are worked out when a command is taken and held until the
  // timer ends, so the slow divides cost a wide divider, not latency.
  always_comb begin
    next_st = st;
    op = cau_pkg::cau_op_t'(cmd_op_i);
    sz = cau_pkg::cau_size_t'(cmd_size_i);
    fm = cau_pkg::cau_form_t'(cmd_form_i);
    mem = (fm == cau_pkg::FM_MEM);
    ah = st.acc[31:16];
    al = st.acc[15:0];
    accept = cmd_valid_i && (st.state == ST_IDLE);
    e_acc = st.acc;
    e_flg = st.flg;
    e_wb = 32'h0;
    e_wreg = 1'b0;
    e_wmem = 1'b0;
    e_cyc = cau_pkg::CYC_ONE;
    neg = 1'b0;
    x = 32'h0;
    y = 32'h0;
    r = 32'h0;
    q = 32'h0;
    rm = 32'h0;
    p = 32'h0;
    sx = 33'h0;
    sy = 33'h0;
    sq = 33'h0;
    srm = 33'h0;
    mg = 33'h0;
    ms = 33'h0;
    case (op)
      cau_pkg::OP_INC, cau_pkg::OP_DEC: begin
        x = msk(cmd_opnd_i, sz);
        r = msk((op == cau_pkg::OP_INC) ? x + 32'h1 : x - 32'h1, sz);
        e_flg[cau_pkg::FLG_N] = msb(r, sz);
        e_flg[cau_pkg::FLG_Z] = (r == 32'h0);
        e_flg[cau_pkg::FLG_V] = (op == cau_pkg::OP_INC) ?
          (msb(r, sz) && !msb(x, sz)) : (!msb(r, sz) && msb(x, sz));
        e_wb = r;
        e_wmem = mem;
        e_wreg = !mem;
        if (sz == cau_pkg::SZ_LONG) begin
          e_cyc = mem ? cau_pkg::CYC_LONG_INCREMENT_MEM : cau_pkg::CYC_LONG_INCREMENT_REG;
        end else if (mem) begin
          e_cyc = cau_pkg::CYC_RMW;
        end else if (sz == cau_pkg::SZ_WORD || op == cau_pkg::OP_DEC) begin
          e_cyc = cau_pkg::CYC_THREE;
        end else begin
          e_cyc = cau_pkg::CYC_TWO;
        end
      end
      cau_pkg::OP_CMP: begin
        if (fm == cau_pkg::FM_IMPL) begin
          x = msk({16'h0, ah}, sz);
          y = msk({16'h0, al}, sz);
        end else begin
          x = msk((sz == cau_pkg::SZ_LONG) ? st.acc : {16'h0, al}, sz);
          y = msk(cmd_opnd_i, sz);
        end
        r = msk(x - y, sz);
        e_flg[cau_pkg::FLG_N] = msb(r, sz);
        e_flg[cau_pkg::FLG_Z] = (r == 32'h0);
        e_flg[cau_pkg::FLG_V] = (msb(x, sz) != msb(y, sz)) &&
                                (msb(r, sz) != msb(x, sz));
        e_flg[cau_pkg::FLG_C] = (x < y);
        if (fm == cau_pkg::FM_IMPL) begin
          e_cyc = cau_pkg::CYC_ONE;
        end else if (sz == cau_pkg::SZ_LONG) begin
          e_cyc = (fm == cau_pkg::FM_IMM) ? cau_pkg::CYC_THREE :
                  mem ? cau_pkg::CYC_COMPARE_LONG_MEM : cau_pkg::CYC_COMPARE_LONG_REG;
        end else begin
          e_cyc = mem ? cau_pkg::CYC_THREE : cau_pkg::CYC_TWO;
        end
      end
      cau_pkg::OP_UNSIGNED_BYTE_DIVIDE_B: begin
        q = {16'h0, ah} / {24'h0, al[7:0]};
        rm = {16'h0, ah} % {24'h0, al[7:0]};
        if (al[7:0] == 8'h0) begin
          e_flg[1:0] = 2'h3;
          e_cyc = cau_pkg::CYC_THREE;
        end else if (q > 32'hff) begin
          e_flg[1:0] = 2'h2;
          e_cyc = cau_pkg::CYC_UNSIGNED_BYTE_DIVIDE_B_OVF;
        end else begin
          e_acc = {8'h0, rm[7:0], 8'h0, q[7:0]};
          e_flg[1:0] = 2'h0;
          e_cyc = cau_pkg::CYC_UNSIGNED_BYTE_DIVIDE_B;
        end
      end
      cau_pkg::OP_UNSIGNED_BYTE_DIVIDE_W: begin
        q = st.acc / {16'h0, cmd_opnd_i[15:0]};
        rm = st.acc % {16'h0, cmd_opnd_i[15:0]};
        if (cmd_opnd_i[15:0] == 16'h0) begin
          e_flg[1:0] = 2'h3;
          e_cyc = cau_pkg::CYC_UNSIGNED_BYTE_DIVIDE_W_ZERO;
        end else if (q > 32'hffff) begin
          e_flg[1:0] = 2'h2;
          e_cyc = cau_pkg::CYC_UNSIGNED_BYTE_DIVIDE_W_OVF;
        end else begin
          e_acc = {ah, q[15:0]};
          e_wb = {16'h0, rm[15:0]};
          e_wreg = 1'b1;
          e_flg[1:0] = 2'h0;
          e_cyc = cau_pkg::CYC_UNSIGNED_BYTE_DIVIDE_W;
        end
      end
      cau_pkg::OP_DIV_B: begin
        sx = {{17{ah[15]}}, ah};
        sy = {{25{al[7]}}, al[7:0]};
        mg = ah[15] ? -sx : sx;
        ms = al[7] ? -sy : sy;
        sq = (ms == 33'h0) ? 33'h0 : $signed(sx) / $signed(sy);
        srm = (ms == 33'h0) ? 33'h0 : $signed(sx) % $signed(sy);
        if (ms == 33'h0) begin
          e_flg[1:0] = 2'h3;
          e_cyc = cau_pkg::CYC_THREE;
        end else if ((mg >> 8) >= ms) begin
          e_flg[1:0] = 2'h2;
          e_cyc = cau_pkg::CYC_DIV_B_PRE;
        end else if (!(&sq[32:7] || ~|sq[32:7])) begin
          e_acc[7:0] = sq[7:0];
          e_flg[1:0] = 2'h2;
          e_cyc = cau_pkg::CYC_DIV_B;
        end else begin
          e_acc = {8'h0, srm[7:0], 8'h0, sq[7:0]};
          e_flg[1:0] = 2'h0;
          e_cyc = cau_pkg::CYC_DIV_B;
        end
      end
      cau_pkg::OP_DIV_W: begin
        neg = st.acc[31];
        sx = {st.acc[31], st.acc};
        sy = {{17{cmd_opnd_i[15]}}, cmd_opnd_i[15:0]};
        mg = neg ? -sx : sx;
        ms = cmd_opnd_i[15] ? -sy : sy;
        sq = (ms == 33'h0) ? 33'h0 : $signed(sx) / $signed(sy);
        srm = (ms == 33'h0) ? 33'h0 : $signed(sx) % $signed(sy);
        if (ms == 33'h0) begin
          e_flg[1:0] = 2'h3;
          e_cyc = cau_pkg::CYC_DIV_W_ZERO;
        end else if ((mg >> 16) >= ms) begin
          e_flg[1:0] = 2'h2;
          e_cyc = cau_pkg::CYC_DIV_W_PRE + {5'h0, neg};
        end else if (!(&sq[32:15] || ~|sq[32:15])) begin
          e_acc[15:0] = sq[15:0];
          e_flg[1:0] = 2'h2;
          e_cyc = cau_pkg::CYC_DIV_W_POST + {5'h0, neg};
        end else begin
          e_acc = {ah, sq[15:0]};
          e_wb = {16'h0, srm[15:0]};
          e_wreg = 1'b1;
          e_flg[1:0] = 2'h0;
          e_cyc = cau_pkg::CYC_DIV_W + {5'h0, neg};
        end
      end
      cau_pkg::OP_UNSIGNED_BYTE_MULTIPLY_B: begin
        p = {24'h0, ah[7:0]} * {24'h0, al[7:0]};
        e_acc = {ah, p[15:0]};
        e_cyc = (ah[7:0] == 8'h0) ? cau_pkg::CYC_THREE :
                cau_pkg::CYC_UNSIGNED_BYTE_MULTIPLY_B;
      end
      cau_pkg::OP_UNSIGNED_BYTE_MULTIPLY_W: begin
        e_acc = {16'h0, ah} * {16'h0, al};
        e_cyc = (ah == 16'h0) ? cau_pkg::CYC_THREE :
                cau_pkg::CYC_UNSIGNED_BYTE_MULTIPLY_W;
      end
      cau_pkg::OP_MUL_B: begin
        p = {{24{ah[7]}}, ah[7:0]} * {{24{al[7]}}, al[7:0]};
        e_acc = {ah, p[15:0]};
        e_cyc = (ah[7:0] == 8'h0) ? cau_pkg::CYC_THREE :
                p[31] ? cau_pkg::CYC_MUL_B_NEG : cau_pkg::CYC_MUL_B_POS;
      end
      cau_pkg::OP_MUL_W: begin
        p = {{16{al[15]}}, al} * {{16{cmd_opnd_i[15]}}, cmd_opnd_i[15:0]};
        e_acc = p;
        e_cyc = (cmd_opnd_i[15:0] == 16'h0) ? cau_pkg::CYC_THREE :
                p[31] ? cau_pkg::CYC_MUL_W_NEG : cau_pkg::CYC_MUL_W_POS;
      end
      cau_pkg::OP_AND, cau_pkg::OP_OR, cau_pkg::OP_XOR, cau_pkg::OP_NOT: begin
        x = {24'h0, mem ? cmd_opnd_i[7:0] : al[7:0]};
        y = {24'h0, mem ? al[7:0] : cmd_opnd_i[7:0]};
        r = (op == cau_pkg::OP_AND) ? (x & y) :
            (op == cau_pkg::OP_OR) ? (x | y) :
            (op == cau_pkg::OP_XOR) ? (x ^ y) : {24'h0, ~x[7:0]};
        e_flg[cau_pkg::FLG_N] = r[7];
        e_flg[cau_pkg::FLG_Z] = (r[7:0] == 8'h0);
        e_flg[cau_pkg::FLG_V] = 1'b0;
        if (mem) begin
          e_wb = r;
          e_wmem = 1'b1;
          e_cyc = cau_pkg::CYC_RMW;
        end else begin
          e_acc[7:0] = r[7:0];
          e_cyc = (fm == cau_pkg::FM_REG) ? cau_pkg::CYC_THREE :
                  cau_pkg::CYC_TWO;
        end
      end
      cau_pkg::OP_WAND, cau_pkg::OP_WOR, cau_pkg::OP_WXOR: begin
        r[15:0] = (op == cau_pkg::OP_WAND) ? (ah & al) :
                  (op == cau_pkg::OP_WOR) ? (ah | al) : (ah ^ al);
        e_acc[15:0] = r[15:0];
        e_flg[cau_pkg::FLG_N] = r[15];
        e_flg[cau_pkg::FLG_Z] = (r[15:0] == 16'h0);
        e_flg[cau_pkg::FLG_V] = 1'b0;
        e_cyc = cau_pkg::CYC_TWO;
      end
      default: begin
        e_cyc = cau_pkg::CYC_ONE;
      end
    endcase

    next_st.done = 1'b0;
    next_st.wb_reg = 1'b0;
    next_st.wb_mem = 1'b0;
    next_st.rdata = 32'h0;
    if (st.state == ST_EXEC) begin
      next_st.run = st.run + 1'b1;
    end
    case (st.state)
      ST_IDLE: begin
        if (accept) begin
          next_st.state = ST_EXEC;
          next_st.ready = 1'b0;
          next_st.run = '0;
          next_st.p_acc = e_acc;
          next_st.p_flg = e_flg;
          next_st.p_wb = e_wb;
          next_st.p_wreg = e_wreg;
          next_st.p_wmem = e_wmem;
          next_st.p_cyc = e_cyc;
          next_st.p_op = op;
        end
      end
      ST_EXEC: begin
        if (last) begin
          next_st.state = ST_IDLE;
          next_st.ready = 1'b1;
          next_st.done = 1'b1;
          next_st.acc = st.p_acc;
          next_st.flg = st.p_flg;
          next_st.wb_data = st.p_wb;
          next_st.wb_reg = st.p_wreg;
          next_st.wb_mem = st.p_wmem;
        end
      end
      default: begin
        next_st.state = ST_IDLE;
        next_st.ready = 1'b1;
      end
    endcase

    // Writes are refused while an instruction is in flight, so software
    // never races the pending result that is about to be committed.
    if (reg_wr_i && st.state == ST_IDLE && !accept) begin
      if (reg_addr_i == cau_pkg::REG_ACC) begin
        next_st.acc = reg_wdata_i;
      end else if (reg_addr_i == cau_pkg::REG_FLAGS) begin
        next_st.flg = reg_wdata_i[3:0];
      end
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        cau_pkg::REG_ACC: next_st.rdata = st.acc;
        cau_pkg::REG_FLAGS: next_st.rdata = {28'h0, st.flg};
        cau_pkg::REG_STATUS: next_st.rdata =
          {25'h0, st.state == ST_EXEC, st.p_cyc};
        default: next_st.rdata = 32'h0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
      st.state <= ST_IDLE;
      st.ready <= 1'b1;
      st.acc <= cau_pkg::ACC_RST;
      st.flg <= cau_pkg::FLG_RST;
    end else begin
      st <= next_st;
    end
  end

  assign cmd_ready_o = st.ready;
  assign done_o = st.done;
  assign wb_reg_o = st.wb_reg;
  assign wb_mem_o = st.wb_mem;
  assign wb_data_o = st.wb_data;
  assign acc_o = st.acc;
  assign flags_o = st.flg;
  assign reg_rdata_o = st.rdata;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);

  a_long_increment_reg_time: assert property (
    accept && op == cau_pkg::OP_INC && sz == cau_pkg::SZ_LONG &&
    fm == cau_pkg::FM_REG |-> ##1 !done_o [*7] ##1 done_o)
    else $error("long register increment not done in 7 cycles");
  a_inc_keep_c: assert property (
    done_o && (st.p_op == cau_pkg::OP_INC || st.p_op == cau_pkg::OP_DEC)
    |-> flags_o[cau_pkg::FLG_C] == $past(flags_o[cau_pkg::FLG_C]))
    else $error("increment changed the carry flag");
  a_rmw_write_back: assert property (
    accept && op == cau_pkg::OP_INC && mem && sz != cau_pkg::SZ_LONG
    |-> ##6 (done_o && wb_mem_o && !wb_reg_o))
    else $error("memory increment did not write back");
  a_cmp_keeps_acc: assert property (
    accept && op == cau_pkg::OP_CMP && fm == cau_pkg::FM_IMPL
    |-> ##2 (done_o && acc_o == $past(acc_o, 2)))
    else $error("implicit compare timing or accumulator wrong");
  a_cmp_imm32_time: assert property (
    accept && op == cau_pkg::OP_CMP && sz == cau_pkg::SZ_LONG &&
    fm == cau_pkg::FM_IMM |-> ##4 done_o)
    else $error("long immediate compare not done in 3 cycles");
  a_unsigned_byte_divide_cycles: assert property (
    done_o && st.p_op == cau_pkg::OP_UNSIGNED_BYTE_DIVIDE_B |-> st.run inside {3, 7, 15})
    else $error("unsigned byte divide cycle count wrong");
  a_unsigned_word_divide_cycles: assert property (
    done_o && st.p_op == cau_pkg::OP_UNSIGNED_BYTE_DIVIDE_W |-> st.run inside {4, 7, 22})
    else $error("unsigned word divide cycle count wrong");
  a_signed_word_divide_cycles: assert property (
    done_o && st.p_op == cau_pkg::OP_DIV_W
    |-> st.run inside {4, 10, 11, 29, 30, 31})
    else $error("signed word divide cycle count wrong");
  a_div_nz_keep: assert property (
    done_o && st.p_op inside {cau_pkg::OP_UNSIGNED_BYTE_DIVIDE_B, cau_pkg::OP_UNSIGNED_BYTE_DIVIDE_W,
                              cau_pkg::OP_DIV_B, cau_pkg::OP_DIV_W}
    |-> flags_o[3:2] == $past(flags_o[3:2]))
    else $error("divide changed N or Z");
  a_mulw_cycles: assert property (
    done_o && st.p_op == cau_pkg::OP_MUL_W |-> st.run inside {3, 16, 19})
    else $error("signed word multiply cycle count wrong");
  a_logic_flags: assert property (
    done_o && st.p_op inside {cau_pkg::OP_AND, cau_pkg::OP_OR,
                              cau_pkg::OP_XOR, cau_pkg::OP_NOT}
    |-> !flags_o[cau_pkg::FLG_V] &&
        flags_o[cau_pkg::FLG_C] == $past(flags_o[cau_pkg::FLG_C]))
    else $error("byte logic flags wrong");

endmodule : cau_alu_core
`default_nettype wire

// ### verilog/cau_pkg.sv
// Shared types and constants of the CPU arithmetic and logic datapath.
// Assumes a single machine clock; used by the datapath and its cycle timer.
package cau_pkg;

  // ------------------------------------------------------------------
  // Command encodings
  // ------------------------------------------------------------------
  typedef enum logic [4:0] {
    OP_INC, OP_DEC, OP_CMP,
    OP_UNSIGNED_BYTE_DIVIDE_B, OP_UNSIGNED_BYTE_DIVIDE_W, OP_DIV_B, OP_DIV_W,
    OP_UNSIGNED_BYTE_MULTIPLY_B, OP_UNSIGNED_BYTE_MULTIPLY_W, OP_MUL_B, OP_MUL_W,
    OP_AND, OP_OR, OP_XOR, OP_NOT,
    OP_WAND, OP_WOR, OP_WXOR
  } cau_op_t;

  typedef enum logic [1:0] {SZ_BYTE, SZ_WORD, SZ_LONG} cau_size_t;
  typedef enum logic [1:0] {FM_IMPL, FM_IMM, FM_REG, FM_MEM} cau_form_t;

  // ------------------------------------------------------------------
  // Flags, register map and reset values
  // ------------------------------------------------------------------
  localparam int FLG_N = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_V = 1;
  localparam int FLG_C = 0;
  localparam logic [1:0] REG_ACC = 2'h0;
  localparam logic [1:0] REG_FLAGS = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [31:0] ACC_RST = 32'h0;
  localparam logic [3:0] FLG_RST = 4'h0;

  // ------------------------------------------------------------------
  // Execution cycle counts
  // ------------------------------------------------------------------
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CYC_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CYC_TWO = 6'h02;
  localparam logic [CNT_W-1:0] CYC_THREE = 6'h03;
  localparam logic [CNT_W-1:0] CYC_RMW = 6'h05;
  localparam logic [CNT_W-1:0] CYC_LONG_INCREMENT_REG = 6'h07;
  localparam logic [CNT_W-1:0] CYC_LONG_INCREMENT_MEM = 6'h09;
  localparam logic [CNT_W-1:0] CYC_COMPARE_LONG_REG = 6'h06;
  localparam logic [CNT_W-1:0] CYC_COMPARE_LONG_MEM = 6'h07;
  localparam logic [CNT_W-1:0] CYC_UNSIGNED_BYTE_DIVIDE_B_OVF = 6'h07;
  localparam logic [CNT_W-1:0] CYC_UNSIGNED_BYTE_DIVIDE_B = 6'h0f;
  localparam logic [CNT_W-1:0] CYC_UNSIGNED_BYTE_DIVIDE_W_ZERO = 6'h04;
  localparam logic [CNT_W-1:0] CYC_UNSIGNED_BYTE_DIVIDE_W_OVF = 6'h07;
  localparam logic [CNT_W-1:0] CYC_UNSIGNED_BYTE_DIVIDE_W = 6'h16;
  localparam logic [CNT_W-1:0] CYC_DIV_B_PRE = 6'h08;
  localparam logic [CNT_W-1:0] CYC_DIV_B = 6'h12;
  localparam logic [CNT_W-1:0] CYC_DIV_W_ZERO = 6'h04;
  localparam logic [CNT_W-1:0] CYC_DIV_W_PRE = 6'h0a;
  localparam logic [CNT_W-1:0] CYC_DIV_W_POST = 6'h1d;
  localparam logic [CNT_W-1:0] CYC_DIV_W = 6'h1e;
  localparam logic [CNT_W-1:0] CYC_UNSIGNED_BYTE_MULTIPLY_B = 6'h07;
  localparam logic [CNT_W-1:0] CYC_UNSIGNED_BYTE_MULTIPLY_W = 6'h0b;
  localparam logic [CNT_W-1:0] CYC_MUL_B_POS = 6'h0c;
  localparam logic [CNT_W-1:0] CYC_MUL_B_NEG = 6'h0d;
  localparam logic [CNT_W-1:0] CYC_MUL_W_POS = 6'h10;
  localparam logic [CNT_W-1:0] CYC_MUL_W_NEG = 6'h13;

endpackage : cau_pkg

// ### verilog/cau_tmr_if.sv
// Handshake between the datapath and its execution cycle timer.
// Assumes both ends run on the same machine clock.
`timescale 1ns/1ps
`default_nettype none
interface cau_tmr_if;
  logic load;
  logic [cau_pkg::CNT_W-1:0] count;
  logic last;
  modport ctl (output load, output count, input last);
  modport tmr (input load, input count, output last);
endinterface : cau_tmr_if
`default_nettype wire

// ### verilog/cau_cycle_timer.sv
// Down counter that times one instruction of the datapath.
// Assumes the load pulse only comes while the counter is idle.
`timescale 1ns/1ps
`default_nettype none
module cau_cycle_timer (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // Timer handshake
  cau_tmr_if.tmr tmr
);

  typedef struct packed {
    logic [cau_pkg::CNT_W-1:0] cnt;
  } cau_tmr_st_t;

  cau_tmr_st_t st;
  cau_tmr_st_t next_st;

  always_comb begin
    next_st = st;
    if (tmr.load) begin
      next_st.cnt = tmr.count;
    end else if (st.cnt != '0) begin
      next_st.cnt = st.cnt - 1'b1;
    end
  end

  assign tmr.last = (st.cnt == cau_pkg::CYC_ONE);

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : cau_cycle_timer
`default_nettype wire

// ### testbench/test_cau_alu_core.sv
// Self-checking bench for the arithmetic and logic datapath.
// Assumes done_o marks the end of each command, N cycles after it is taken.
`timescale 1ns/1ps
`default_nettype none
module test_cau_alu_core;
  typedef struct {int n; logic [31:0] v; int s; logic m;} cau_exp_t;
  localparam logic [1:0] imp = cau_pkg::FM_IMPL, imm = cau_pkg::FM_IMM;
  localparam logic [1:0] rgf = cau_pkg::FM_REG, mem = cau_pkg::FM_MEM;
  localparam logic [1:0] wrd = cau_pkg::SZ_WORD, lng = cau_pkg::SZ_LONG;
  logic clk = 0, rst_b = 0, vld = 0, wr = 0, rd = 0;
  logic [4:0] op = 0;
  logic [1:0] sz = 0, fm = 0, ad = 0;
  logic [31:0] od = 0, wd = 0, r;
  wire logic rdy, done, wbr, wbm;
  wire logic [31:0] wbd, acc, rdat;
  wire logic [3:0] flg;
  int cyc = 0, t0 = 0, err_count = 0, check_count = 0;
  cau_exp_t q[$], e;

  cau_alu_core u_cau_alu_core (.core_clk_i(clk), .rst_b_i(rst_b),
    .cmd_valid_i(vld), .cmd_op_i(op), .cmd_size_i(sz), .cmd_form_i(fm),
    .cmd_opnd_i(od), .cmd_ready_o(rdy), .done_o(done), .wb_reg_o(wbr),
    .wb_mem_o(wbm), .wb_data_o(wbd), .acc_o(acc), .flags_o(flg),
    .reg_addr_i(ad), .reg_wdata_i(wd), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdat));

  initial forever #25 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  task chk(input logic [31:0] s, input logic [31:0] x);
    check_count++;
    if (s !== x) begin
      err_count++;
      $display("[ERR] %0t seen %h exp %h", $time, s, x);
    end
  endtask : chk

  task give_verdict;
    $display("mismatches %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict

  task wreg(input logic [1:0] a, input logic [31:0] d);
    ad <= a;
    wd <= d;
    wr <= 1;
    @(posedge clk) wr <= 0;
  endtask : wreg

  task rreg(input logic [1:0] a, input logic [31:0] x);
    ad <= a;
    rd <= 1;
    @(posedge clk) rd <= 0;
    @(negedge clk) chk(rdat, x);
    @(posedge clk);
  endtask : rreg

  // The expectation is queued before the command goes out, so the
  // watcher below can never see a completion ahead of its note.
  task cmd(input logic [4:0] o, input logic [1:0] z, input logic [1:0] f,
      input logic [31:0] d, input int n, input logic [31:0] v, input int s);
    op <= o;
    sz <= z;
    fm <= f;
    od <= d;
    vld <= 1;
    q.push_back('{n, v, s, f == mem});
    @(posedge clk) vld <= 0;
    @(negedge clk) t0 = cyc;
    chk(rdy, 1'b0);
    repeat (40) if (q.size() > 0) @(negedge clk);
    @(posedge clk);
  endtask : cmd

  always @(negedge clk) begin
    if (done === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk(cyc - t0, e.n);
      chk(wbm, e.m);
      chk(wbr, e.s == 0 && !e.m);
      chk(rdy, 1'b1);
      chk(e.s == 0 ? wbd : e.s == 1 ? acc : {28'h0, flg}, e.v);
    end
  end

  initial begin
    #(50 * 3000);
    err_count++;
    give_verdict();
  end

  initial begin
    r = $urandom(49);
    repeat (20) @(posedge clk);
    rst_b <= 1;
    @(posedge clk);
    r = $urandom;
    wreg(cau_pkg::REG_ACC, r);
    rreg(cau_pkg::REG_ACC, r);
    rreg(2'h3, 32'h0);
    cmd(cau_pkg::OP_INC, lng, rgf, r, 7, r + 1, 0);
    cmd(cau_pkg::OP_DEC, lng, mem, r, 9, r - 1, 0);
    wreg(cau_pkg::REG_ACC, 32'h0001_0002);
    cmd(cau_pkg::OP_CMP, wrd, imp, 0, 1, 32'h9, 2);
    wreg(cau_pkg::REG_ACC, r);
    cmd(cau_pkg::OP_CMP, lng, imm, r, 3, 32'h4, 2);
    wreg(cau_pkg::REG_ACC, 32'h0064_0007);
    cmd(cau_pkg::OP_UNSIGNED_BYTE_DIVIDE_B, 0, imp, 0, 15, 32'h0002_000e, 1);
    wreg(cau_pkg::REG_ACC, 32'h0064_0000);
    cmd(cau_pkg::OP_UNSIGNED_BYTE_DIVIDE_B, 0, imp, 0, 3, 32'h7, 2);
    wreg(cau_pkg::REG_ACC, 32'h0000_0005);
    cmd(cau_pkg::OP_UNSIGNED_BYTE_MULTIPLY_B, 0, imp, 0, 3, 32'h0, 1);
    wreg(cau_pkg::REG_ACC, 32'h0003_0005);
    cmd(cau_pkg::OP_UNSIGNED_BYTE_MULTIPLY_B, 0, imp, 0, 7, 32'h0003_000f, 1);
    cmd(cau_pkg::OP_MUL_W, 0, rgf, 0, 3, 32'h0, 1);
    wreg(cau_pkg::REG_ACC, 32'h0000_00f3);
    cmd(cau_pkg::OP_AND, 0, imm, 32'h3c, 2, 32'h0000_0030, 1);
    cmd(cau_pkg::OP_OR, 0, rgf, 32'h0f, 3, 32'h0000_003f, 1);
    wreg(cau_pkg::REG_ACC, 32'h0f0f_00ff);
    cmd(cau_pkg::OP_WAND, 0, imp, 0, 2, 32'h0f0f_000f, 1);
    chk(q.size(), 0);
    give_verdict();
  end
endmodule : test_cau_alu_core
`default_nettype wire
